// ===== line_error_counters_and_port_select.sv
`timescale 1ns/1ns
// Summary of operation
// - Code violation on near or far side increments block error count.
// - Block error count saturates at 255, never wraps.
// - Reading block error count returns it, then clears it to zero.
// - Short monitor request and long read at 12h both return count.
// - 16-bit bit error count at 13h/14h counts while measuring.
// - Reading low byte 13h clears whole bit error count.
// - Per-line accesses go to the bank named by port select 1Ch.
// - Select bits 1:0 are binary port number 0 to 3.
// - Bit error counting and zero sending only when measurement field equals 11.
// - Port select holds until written again.
module line_error_counters_and_port_select #(
	parameter int PORTS = line_err_pkg::NUM_PORTS
) (
	// Clock and reset
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst_n,
	// Monitor access port
	input  wire line_err_pkg::access_type i_acc,
	input  wire logic [7:0]             i_addr,
	input  wire logic [7:0]             i_wdata,
	output logic [7:0]                  o_rdata,
	output logic                        o_rvalid,
	// Line events, one bit per port
	input  wire logic [PORTS-1:0]       i_code_viol_near,
	input  wire logic [PORTS-1:0]       i_code_viol_far,
	input  wire logic [PORTS-1:0]       i_bit_err,
	// Status
	output logic                        o_send_zeros,
	output logic [1:0]                  o_port_sel
);
	// ********************************************************
	// Registers
	// ********************************************************
	logic [7:0] test_reg;
	logic [7:0] blk_cnt [PORTS];
	logic [15:0] bit_cnt [PORTS];

	// ********************************************************
	// Decode
	// ********************************************************
	// Access of one kind at one register address
	function automatic logic acc_at(
		input line_err_pkg::access_type kind,
		input line_err_pkg::access_type want,
		input logic [7:0]               addr,
		input logic [7:0]               want_addr
	);
		return (kind == want) && (addr == want_addr);
	endfunction

	wire logic is_rd   = (i_acc == line_err_pkg::ACC_READ);
	wire logic is_sh   = (i_acc == line_err_pkg::ACC_SHORT);
	wire logic rd_blk  = is_sh || acc_at(i_acc, line_err_pkg::ACC_READ,
		i_addr, line_err_pkg::ADDR_BLOCK_ERR);
	wire logic rd_lo   = acc_at(i_acc, line_err_pkg::ACC_READ, i_addr,
		line_err_pkg::ADDR_BIT_ERR_LO);
	wire logic rd_hi   = acc_at(i_acc, line_err_pkg::ACC_READ, i_addr,
		line_err_pkg::ADDR_BIT_ERR_HI);
	wire logic rd_sel  = acc_at(i_acc, line_err_pkg::ACC_READ, i_addr,
		line_err_pkg::ADDR_PORT_SEL);
	wire logic rd_test = acc_at(i_acc, line_err_pkg::ACC_READ, i_addr,
		line_err_pkg::ADDR_TEST);
	// Writes land only on the two writable registers
	wire logic wr_sel  = acc_at(i_acc, line_err_pkg::ACC_WRITE, i_addr,
		line_err_pkg::ADDR_PORT_SEL);
	wire logic wr_test = acc_at(i_acc, line_err_pkg::ACC_WRITE, i_addr,
		line_err_pkg::ADDR_TEST);
	wire logic meas_on = (test_reg[line_err_pkg::MEAS_LSB +: 2]
		== line_err_pkg::MEAS_ON);
	wire logic [7:0] blk_sel = blk_cnt[o_port_sel];
	wire logic [15:0] bit_sel = bit_cnt[o_port_sel];
	wire logic [7:0] sel_byte = {6'h00, o_port_sel};

	// Read mux; unmapped reads answer zero
	wire logic [7:0] next_rdata =
		rd_blk  ? blk_sel :
		rd_lo   ? bit_sel[7:0] :
		rd_hi   ? bit_sel[15:8] :
		rd_sel  ? sel_byte :
		rd_test ? test_reg : 8'h00;

	// ********************************************************
	// Per-port counter banks
	// ********************************************************
	genvar g;
	generate
		for (g = 0; g < PORTS; g++) begin : g_port
			// Clear only the selected bank; index cut to select width
			wire logic hit = (o_port_sel == 2'(g));
			port_err_counters #(.BIT_W(16)) u_cnt (
				.i_ref_clk        (i_ref_clk),
				.i_rst_n          (i_rst_n),
				.i_code_viol_near (i_code_viol_near[g]),
				.i_code_viol_far  (i_code_viol_far[g]),
				.i_bit_err        (i_bit_err[g]),
				.i_meas_on        (meas_on),
				.i_clr_block      (hit && rd_blk),
				// Low byte read clears; high does not
				.i_clr_bit        (hit && rd_lo),
				.o_block_cnt      (blk_cnt[g]),
				.o_bit_cnt        (bit_cnt[g])
			);
		end
	endgenerate

	// Read answer flops
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata  <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rdata  <= next_rdata;
			o_rvalid <= is_rd || is_sh;
		end
	end

	// Select and test registers hold until written
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_port_sel   <= line_err_pkg::PORT_SEL_RST;
			test_reg     <= line_err_pkg::TEST_RST;
			o_send_zeros <= 1'b0;
		end else begin
			// Binary port number in low bits
			if (wr_sel) begin
				o_port_sel <= i_wdata[1:0];
			end
			if (wr_test) begin
				test_reg <= i_wdata;
			end
			o_send_zeros <= meas_on;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	// Read returns the count, then clears the bank
	a_blk_read: assert property (rd_blk |=> o_rdata == $past(blk_sel))
		else $error("block count read wrong");
	a_blk_clear: assert property (rd_blk
		|=> blk_cnt[$past(o_port_sel)] == line_err_pkg::BLOCK_ERR_RST)
		else $error("block count not cleared by read");
	a_blk_sat: assert property (
		blk_cnt[0] == line_err_pkg::BLOCK_ERR_MAX
		&& !(rd_blk && o_port_sel == 2'h0)
		|=> blk_cnt[0] == line_err_pkg::BLOCK_ERR_MAX)
		else $error("block count left saturation");
	// Far or near violation counts one
	a_blk_inc: assert property (
		i_code_viol_far[0] && blk_cnt[0] != line_err_pkg::BLOCK_ERR_MAX
		&& !(rd_blk && o_port_sel == 2'h0)
		|=> blk_cnt[0] == $past(blk_cnt[0]) + 8'h01)
		else $error("block count missed violation");
	a_near_inc: assert property (
		i_code_viol_near[1] && !i_code_viol_far[1]
		&& blk_cnt[1] != line_err_pkg::BLOCK_ERR_MAX
		&& !(rd_blk && o_port_sel == 2'h1)
		|=> blk_cnt[1] == $past(blk_cnt[1]) + 8'h01)
		else $error("near violation not counted");
	// Short and long requests both answered
	a_short_ans: assert property (is_sh
		|=> o_rvalid && o_rdata == $past(blk_sel))
		else $error("short request answered wrongly");
	a_read_answer: assert property (is_rd |=> o_rvalid)
		else $error("read not answered");
	// Bit count frozen while measurement is off
	a_bit_idle: assert property (!meas_on && !rd_lo
		|=> $stable(bit_cnt[0]))
		else $error("bit count moved while idle");
	// Bit error counts one while measuring
	a_bit_inc: assert property (
		meas_on && i_bit_err[0] && !(&bit_cnt[0])
		&& !(rd_lo && o_port_sel == 2'h0)
		|=> bit_cnt[0] == $past(bit_cnt[0]) + 16'h0001)
		else $error("bit error not counted");
	a_hi_read: assert property (rd_hi
		|=> o_rdata == $past(bit_sel[15:8]))
		else $error("high byte read wrong");
	// Low byte read clears all sixteen bits
	a_bit_clear: assert property (rd_lo
		|=> bit_cnt[$past(o_port_sel)] == line_err_pkg::BIT_ERR_RST)
		else $error("bit count not cleared");
	// High byte read keeps the count
	a_hi_keep: assert property (rd_hi && !meas_on
		|=> bit_cnt[$past(o_port_sel)] == $past(bit_sel))
		else $error("high byte read changed count");
	a_sel_hold: assert property (!wr_sel |=> $stable(o_port_sel))
		else $error("port select changed without write");
	// Written value lands in the select
	a_sel_write: assert property (wr_sel
		|=> o_port_sel == $past(i_wdata[1:0]))
		else $error("port select write lost");
	a_sel_read: assert property (rd_sel
		|=> o_rdata == {6'h00, $past(o_port_sel)})
		else $error("port select read wrong");
	// Reads come from the selected bank
	a_bank_steer: assert property (rd_lo
		|=> o_rdata == $past(bit_cnt[o_port_sel][7:0]))
		else $error("read from wrong bank");
	// Zero sending follows the measurement field
	a_zero_send: assert property (meas_on |=> o_send_zeros)
		else $error("zero sending not on");
	a_zero_off: assert property (!meas_on |=> !o_send_zeros)
		else $error("zero sending not off");

	// Main scenarios reached
	c_sat: cover property (blk_cnt[0] == line_err_pkg::BLOCK_ERR_MAX);
	c_short: cover property (is_sh);
	c_meas: cover property (meas_on && i_bit_err[0]);
	c_port3: cover property (o_port_sel == 2'h3 && rd_lo);
	c_lo_clear: cover property (rd_lo && |bit_sel);
endmodule

// ===== line_err_pkg.sv
package line_err_pkg;
	// ********************************************************
	// Register map
	// ********************************************************
	localparam logic [7:0] ADDR_TEST       = 8'h0F;
	localparam logic [7:0] ADDR_BLOCK_ERR  = 8'h12;
	localparam logic [7:0] ADDR_BIT_ERR_LO = 8'h13;
	localparam logic [7:0] ADDR_BIT_ERR_HI = 8'h14;
	localparam logic [7:0] ADDR_PORT_SEL   = 8'h1C;
	// ********************************************************
	// Fields and reset values
	// ********************************************************
	localparam int         MEAS_LSB        = 4;
	localparam logic [1:0] MEAS_ON         = 2'h3;
	localparam logic [7:0] BLOCK_ERR_MAX   = 8'hFF;
	localparam logic [7:0] BLOCK_ERR_RST   = 8'h00;
	localparam logic [15:0] BIT_ERR_RST    = 16'h0000;
	localparam logic [7:0] TEST_RST        = 8'h00;
	localparam logic [1:0] PORT_SEL_RST    = 2'h0;
	localparam int         NUM_PORTS       = 4;
	// Access kinds of a monitor request
	typedef enum logic [1:0] {
		ACC_NONE  = 2'b00,
		ACC_READ  = 2'b01,
		ACC_WRITE = 2'b10,
		ACC_SHORT = 2'b11
	} access_type;
endpackage

// ===== port_err_counters.sv
`timescale 1ns/1ns
// One line port: saturating block error and 16-bit bit error counters
module port_err_counters #(
	parameter int BIT_W = 16
) (
	// Clock and reset
	input  wire logic             i_ref_clk,
	input  wire logic             i_rst_n,
	// Error events
	input  wire logic             i_code_viol_near,
	input  wire logic             i_code_viol_far,
	input  wire logic             i_bit_err,
	input  wire logic             i_meas_on,
	// Clear strobes from the read path
	input  wire logic             i_clr_block,
	input  wire logic             i_clr_bit,
	// Counts
	output logic [7:0]            o_block_cnt,
	output logic [BIT_W-1:0]      o_bit_cnt
);
	wire logic viol = i_code_viol_near | i_code_viol_far;
	wire logic blk_full = (o_block_cnt == line_err_pkg::BLOCK_ERR_MAX);
	wire logic bit_full = &o_bit_cnt;
	wire logic [7:0] next_block = i_clr_block ? line_err_pkg::BLOCK_ERR_RST
		: (viol && !blk_full) ? o_block_cnt + 8'h01 : o_block_cnt;
	wire logic [BIT_W-1:0] next_bit = i_clr_bit ? '0
		: (i_meas_on && i_bit_err && !bit_full)
		? o_bit_cnt + {{(BIT_W-1){1'b0}}, 1'b1} : o_bit_cnt;

	// Counter flops; a read clear discards a same-cycle event
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_block_cnt <= line_err_pkg::BLOCK_ERR_RST;
			o_bit_cnt   <= '0;
		end else begin
			o_block_cnt <= next_block;
			o_bit_cnt   <= next_bit;
		end
	end
endmodule

// ===== mon_ctrl.sv
`timescale 1ns/1ns
// Controller model: one monitor access at a time
module mon_ctrl (
	// Clock and answer
	input  wire logic                i_ref_clk,
	input  wire logic [7:0]          i_rdata,
	input  wire logic                i_rvalid,
	// Request
	output line_err_pkg::access_type o_acc,
	output logic [7:0]               o_addr,
	output logic [7:0]               o_wdata
);
	logic to;
	// Idle bus at time zero
	initial begin
		o_acc = line_err_pkg::ACC_NONE;
		o_addr = 8'h00;
		o_wdata = 8'h00;
		to = 1'b0;
	end
	task automatic access(input line_err_pkg::access_type k,
		input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		q = 8'h00;
		n = 0;
		@(posedge i_ref_clk);
		#1;
		o_acc = k;
		o_addr = a;
		o_wdata = d;
		@(posedge i_ref_clk);
		#1;
		o_acc = line_err_pkg::ACC_NONE;
		// Released lines show the inverse, not the stale value
		o_addr = ~a;
		o_wdata = ~d;
		if (k == line_err_pkg::ACC_WRITE)
			return;
		while (i_rvalid !== 1'b1 && n < 4) begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		to = (i_rvalid !== 1'b1);
		q = i_rdata;
	endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ns
module testbench;
	logic                     i_ref_clk, i_rst_n, rvalid, zeros;
	line_err_pkg::access_type acc;
	logic [7:0]               addr, wdata, rdata, q;
	logic [1:0]               psel;
	logic [3:0]               near, far, berr;
	int                       fails, tests_run, n, cnt[4];
	line_error_counters_and_port_select u_dut (.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n), .i_acc(acc), .i_addr(addr), .i_wdata(wdata),
		.o_rdata(rdata), .o_rvalid(rvalid), .i_code_viol_near(near),
		.i_code_viol_far(far), .i_bit_err(berr), .o_send_zeros(zeros),
		.o_port_sel(psel));
	mon_ctrl u_ctrl (.i_ref_clk(i_ref_clk), .i_rdata(rdata),
		.i_rvalid(rvalid), .o_acc(acc), .o_addr(addr), .o_wdata(wdata));
	// Free-running 250 MHz clock
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end
	// Saturating block count expected after c violations
	function automatic logic [7:0] exp_block(input int c);
		if (c > int'(line_err_pkg::BLOCK_ERR_MAX))
			return line_err_pkg::BLOCK_ERR_MAX;
		return 8'(c);
	endfunction
	// Test register word with the measurement field set to f
	function automatic logic [7:0] test_word(input logic [1:0] f);
		return 8'(f) << line_err_pkg::MEAS_LSB;
	endfunction
	task automatic final_report;
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (u_ctrl.to || g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
		if (u_ctrl.to)
			final_report();
	endtask
	// Read, long or short, and compare
	task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] e);
		u_ctrl.access(s ? line_err_pkg::ACC_SHORT : line_err_pkg::ACC_READ,
			a, 8'h00, q);
		chk(q, e);
	endtask
	// One event per cycle on port p: 0 near, 1 far, 2 bit error
	task automatic pulse(input int p, input int k, input int c);
		repeat (c) begin
			@(posedge i_ref_clk);
			#1;
			near = (k == 0) ? 4'h1 << p : 4'h0;
			far = (k == 1) ? 4'h1 << p : 4'h0;
			berr = (k == 2) ? 4'h1 << p : 4'h0;
		end
		@(posedge i_ref_clk);
		#1;
		{near, far, berr} = 12'h000;
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{near, far, berr} = 12'h000;
		fails = 0;
		tests_run = 0;
		i_rst_n = 1'b0;
		repeat (3) @(posedge i_ref_clk);
		#1;
		i_rst_n = 1'b1;
		void'($urandom(32'hB50AE837));
		foreach (cnt[i]) rd(1'b0, 8'h12 + 8'(i), 8'h00);
		rd(1'b0, 8'h1C, 8'h00);
		rd(1'b0, 8'h33, 8'h00);
		$display("reset test done");
		// Random count of 2 to 40 per port, near and far mixed
		foreach (cnt[p]) begin
			cnt[p] = $urandom_range(2, 40);
			n = $urandom_range(1, cnt[p] - 1);
			pulse(p, 0, n);
			pulse(p, 1, cnt[p] - n);
		end
		for (int p = 3; p >= 0; p--) begin
			u_ctrl.access(line_err_pkg::ACC_WRITE, 8'h1C, 8'(p), q);
			rd(p[0], 8'h12, exp_block(cnt[p]));
			chk({6'h00, psel}, 8'(p));
			rd(1'b0, 8'h12, 8'h00);
			rd(1'b0, 8'h14, 8'h00);
			rd(1'b0, 8'h13, 8'h00);
		end
		$display("port test done");
		n = $urandom_range(250, 260);
		pulse(0, 0, n);
		rd(1'b1, 8'h12, exp_block(n));
		pulse(0, 0, 300);
		rd(1'b1, 8'h12, exp_block(300));
		pulse(0, 2, 5);
		n = $urandom_range(1, 2);
		u_ctrl.access(line_err_pkg::ACC_WRITE, 8'h0F, test_word(2'(n)), q);
		pulse(0, 2, 5);
		chk({7'h00, zeros}, 8'h00);
		u_ctrl.access(line_err_pkg::ACC_WRITE, 8'h0F,
			test_word(line_err_pkg::MEAS_ON), q);
		n = $urandom_range(256, 700);
		pulse(0, 2, n);
		chk({7'h00, zeros}, 8'h01);
		rd(1'b0, 8'h0F, test_word(line_err_pkg::MEAS_ON));
		rd(1'b0, 8'h14, 8'(n >> 8));
		rd(1'b0, 8'h14, 8'(n >> 8));
		rd(1'b0, 8'h13, 8'(n));
		rd(1'b0, 8'h14, 8'h00);
		u_ctrl.access(line_err_pkg::ACC_WRITE, 8'h0F, 8'h00, q);
		rd(1'b0, 8'h0F, 8'h00);
		chk({7'h00, zeros}, 8'h00);
		$display("bit error test done");
		final_report();
	end
endmodule
